// File: shared/fsp_defs.svh
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH

// Register offsets on the plain register port
`define FSP_OFF_OPTION 8'h00
`define FSP_OFF_CONFIG 8'h01
`define FSP_OFF_PROTECT 8'h02
`define FSP_OFF_STATUS 8'h03
`define FSP_OFF_MASK 8'h04

// Option image fields
`define FSP_OPT_UNLOCK_ALLOW 7
`define FSP_OPT_REDIRECT_OFF 6
`define FSP_OPT_LOAD_MASK 8'hC3
`define FSP_SEC_UNSECURED 2'h2

// Configuration fields
`define FSP_CFG_KEY_ROUTE 5
`define FSP_CFG_WR_MASK 8'hE0

// Protection image fields
`define FSP_PROT_OFF_BIT 0

// Status and mask bit positions
`define FSP_ST_VIOL 0
`define FSP_ST_UNLOCK 1
`define FSP_ST_BLOCKED 2
`define FSP_ST_MASK 8'h07

// Reset values
`define FSP_RST_BYTE 8'h00

// Key window and key length
`define FSP_KEY_BASE 16'hFFB0
`define FSP_KEY_TOP 16'hFFB7
`define FSP_KEY_LAST 3'h7

// Command codes seen by the protection check
`define FSP_CMD_BLANK 8'h05
`define FSP_CMD_PROG 8'h20
`define FSP_CMD_BURST 8'h25
`define FSP_CMD_PAGE 8'h40
`define FSP_CMD_MASS 8'h41

// Address bits below the boundary field
`define FSP_LOW_ONES 9'h1FF

`endif

// File: shared/fsp_pkg.sv
`default_nettype none

package fsp_pkg;

  // One access toward RAM or the program memory
  typedef struct packed {
    logic valid;
    logic dbg;
    logic wr;
    logic [15:0] addr;
    logic [7:0] data;
  } fsp_acc_t;

  // One launched program or erase command
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [15:0] addr;
  } fsp_cmd_t;

  typedef enum logic [0:0] {FSP_LD_LOAD, FSP_LD_RUN} fsp_ld_t;
  typedef enum logic [0:0] {FSP_KC_IDLE, FSP_KC_COLLECT} fsp_kc_t;

endpackage

`default_nettype wire

// File: hw/fsp_key_cmp.sv
`include "fsp_defs.svh"
`default_nettype none

module fsp_key_cmp
  import fsp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic key_wr,
  input wire logic [2:0] key_idx,
  input wire logic [7:0] key_byte,
  input wire logic [63:0] nv_unlock_key,
  output logic key_match
);

  fsp_kc_t state_q;
  logic [2:0] next_q;
  logic good_q;
  logic [7:0] want;

  // Byte i of the stored key sits in bits 8i+7..8i
  assign want = nv_unlock_key[{key_idx, 3'h0} +: 8];

  ////////////////////////////////////////////////////////////////////
  // Sequence tracker: bytes must arrive at offsets 0..7 in order
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= FSP_KC_IDLE;
      next_q <= 3'h0;
      good_q <= 1'b0;
      key_match <= 1'b0;
    end else if (clk_en) begin
      key_match <= 1'b0;
      case (state_q)
        FSP_KC_IDLE: begin
          if (key_wr && key_idx == 3'h0) begin
            state_q <= FSP_KC_COLLECT;
            next_q <= 3'h1;
            good_q <= (key_byte == want);
          end
        end
        FSP_KC_COLLECT: begin
          if (key_wr) begin
            if (key_idx != next_q) begin
              // Out of order breaks the sequence; offset 0 restarts it
              state_q <= (key_idx == 3'h0) ? FSP_KC_COLLECT : FSP_KC_IDLE;
              next_q <= 3'h1;
              good_q <= (key_idx == 3'h0) && (key_byte == want);
            end else if (key_idx == `FSP_KEY_LAST) begin
              state_q <= FSP_KC_IDLE;
              key_match <= good_q && (key_byte == want);
            end else begin
              next_q <= next_q + 3'h1;
              good_q <= good_q && (key_byte == want);
            end
          end
        end
        default: state_q <= FSP_KC_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// File: hw/fsp_top.sv
// The implementer's own choices: the register addresses and the plain strobed port.
`include "fsp_defs.svh"
`default_nettype none

module fsp_top
  import fsp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_dbg,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] nv_option_source,
  input wire logic [7:0] nv_protect_source,
  input wire logic [63:0] nv_unlock_key,
  input wire fsp_acc_t mem_req,
  output logic mem_grant,
  output logic mem_block,
  output fsp_cmd_t launch_out,
  input wire fsp_cmd_t cmd_in,
  output fsp_cmd_t cmd_go,
  input wire logic blank_ok,
  output logic secured,
  output logic vector_redirect_off,
  output logic images_ready,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////
  // Declarations
  fsp_ld_t ld_q;
  logic [7:0] opt_q;
  logic [7:0] cfg_q;
  logic [7:0] prot_q;
  logic [7:0] stat_q;
  logic [7:0] stat_d;
  logic [7:0] mask_q;
  logic [7:0] rdata_d;
  logic is_secure;
  logic in_window;
  logic key_route;
  logic key_ok;
  logic key_wr;
  logic key_match;
  logic viol_ev;
  logic unlock_ev;
  logic block_ev;
  logic stat_rd;
  logic run;
  logic dbg_locked;

  ////////////////////////////////////////////////////////////////////
  // Helpers
  // Only the code 1:0 is unsecured
  function automatic logic sec_decode(input logic [1:0] code);
    sec_decode = (code != `FSP_SEC_UNSECURED);
  endfunction

  // Address lies above the last unprotected location
  function automatic logic is_protected(input logic [15:0] addr,
                                        input logic [7:0] prot);
    logic [15:0] last;
    // Boundary 7F with protection on leaves nothing protected
    last = {prot[7:1], `FSP_LOW_ONES};
    is_protected = !prot[`FSP_PROT_OFF_BIT] && (addr > last);
  endfunction

  // Any protected block at all makes a mass erase illegal
  function automatic logic any_protected(input logic [7:0] prot);
    any_protected = is_protected(16'hFFFF, prot);
  endfunction

  // Run once the load cycle has passed
  assign run = (ld_q == FSP_LD_RUN);
  assign is_secure = sec_decode(opt_q[1:0]);
  assign key_route = cfg_q[`FSP_CFG_KEY_ROUTE];
  assign in_window = mem_req.valid && mem_req.wr &&
                     mem_req.addr >= `FSP_KEY_BASE &&
                     mem_req.addr <= `FSP_KEY_TOP;

  // Key bytes accepted only from core firmware, while secured and allowed
  assign key_ok = opt_q[`FSP_OPT_UNLOCK_ALLOW] && is_secure
                  && !mem_req.dbg;
  // Route 1 steers window writes away from the command path
  assign key_wr = run && in_window && key_route && key_ok;

  // Debug-port access while secured; refused wherever it shows up
  assign dbg_locked = mem_req.valid && mem_req.dbg && is_secure;

  ////////////////////////////////////////////////////////////////////
  // Backdoor key comparison
  fsp_key_cmp u_key_cmp (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .key_wr(key_wr),
    .key_idx(mem_req.addr[2:0]),
    .key_byte(mem_req.data),
    .nv_unlock_key(nv_unlock_key),
    .key_match(key_match)
  );

  ////////////////////////////////////////////////////////////////////
  // Image loading: images are captured in the first cycle after reset
  // release, since a sync reset may only load constants
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ld_q <= FSP_LD_LOAD;
    end else if (clk_en) begin
      case (ld_q)
        FSP_LD_LOAD: ld_q <= FSP_LD_RUN;
        FSP_LD_RUN: ld_q <= FSP_LD_RUN;
        default: ld_q <= FSP_LD_LOAD;
      endcase
    end
  end

  // Option image: loaded once, only the security field ever changes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      opt_q <= `FSP_RST_BYTE;
    end else if (clk_en) begin
      if (!run) begin
        // Unused bits 5..2 always read zero
        opt_q <= nv_option_source & `FSP_OPT_LOAD_MASK;
      end else if (key_match || blank_ok) begin
        // One-way until the next reset
        opt_q[1:0] <= `FSP_SEC_UNSECURED;
      end
    end
  end

  // Protection image: user writes dropped, debug writes taken
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prot_q <= `FSP_RST_BYTE;
    end else if (clk_en) begin
      if (!run) begin
        prot_q <= nv_protect_source;
      end else if (reg_wr && reg_addr == `FSP_OFF_PROTECT && reg_dbg) begin
        prot_q <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Configuration and mask registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg_q <= `FSP_RST_BYTE;
    end else if (clk_en && reg_wr && reg_addr == `FSP_OFF_CONFIG) begin
      cfg_q <= reg_wdata & `FSP_CFG_WR_MASK;
    end
  end

  // Interrupt mask, same layout as the status bits
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mask_q <= `FSP_RST_BYTE;
    end else if (clk_en && reg_wr && reg_addr == `FSP_OFF_MASK) begin
      mask_q <= reg_wdata & `FSP_ST_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Memory access gate; decision is registered, one cycle after request.
  // Requests before the images are loaded get no answer at all.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mem_block <= 1'b0;
    end else if (clk_en) begin
      // Debug port counts as an unsecured source
      mem_block <= run && dbg_locked;
    end
  end

  // Grant is the exact complement of block for a valid request once the images are loaded
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mem_grant <= 1'b0;
    end else if (clk_en) begin
      mem_grant <= run && mem_req.valid && !dbg_locked;
    end
  end

  // Key-window writes with route 0 start a command; others pass through.
  // Route 1 writes never launch, even when the key write itself is refused.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      launch_out <= '0;
    end else if (clk_en) begin
      launch_out.valid <= run && in_window && !key_route && !dbg_locked;
      // Payload follows the bus every cycle; only valid matters
      launch_out.code <= mem_req.data;
      launch_out.addr <= mem_req.addr;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Protection check of launched commands
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmd_go <= '0;
    end else if (clk_en) begin
      cmd_go.valid <= run && cmd_in.valid && !viol_ev;
      // Payload copied every cycle; consumers look at valid only
      cmd_go.code <= cmd_in.code;
      cmd_go.addr <= cmd_in.addr;
    end
  end

  // Violation decode per command kind; blank check is never refused
  always_comb begin
    viol_ev = 1'b0;
    if (run && cmd_in.valid) begin
      if (cmd_in.code == `FSP_CMD_PROG || cmd_in.code == `FSP_CMD_BURST) begin
        viol_ev = is_protected(cmd_in.addr, prot_q);
      end else if (cmd_in.code == `FSP_CMD_PAGE) begin
        // Page of 512 bytes: its top byte decides
        viol_ev = is_protected({cmd_in.addr[15:9], `FSP_LOW_ONES}, prot_q);
      end else if (cmd_in.code == `FSP_CMD_MASS) begin
        viol_ev = any_protected(prot_q);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Events, sticky status and interrupt
  assign unlock_ev = run && is_secure && (key_match || blank_ok);
  assign block_ev = run && dbg_locked;
  assign stat_rd = reg_rd && reg_addr == `FSP_OFF_STATUS;

  // Read clears, but a new event in that cycle still sets its bit
  always_comb begin
    stat_d = stat_rd ? `FSP_RST_BYTE : stat_q;
    if (viol_ev) begin
      stat_d[`FSP_ST_VIOL] = 1'b1;
    end
    if (unlock_ev) begin
      stat_d[`FSP_ST_UNLOCK] = 1'b1;
    end
    if (block_ev) begin
      stat_d[`FSP_ST_BLOCKED] = 1'b1;
    end
  end

  // Sticky status, frozen with the clock enable
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stat_q <= `FSP_RST_BYTE;
    end else if (clk_en) begin
      stat_q <= stat_d;
    end
  end

  // Level interrupt; uses next status so it rises with the bit
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(stat_d & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Security state; shown as secured until the images have loaded
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      secured <= 1'b1;
    end else if (clk_en) begin
      secured <= run ? is_secure : 1'b1;
    end
  end

  // Vector redirection; left enabled until the option image is in
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      vector_redirect_off <= 1'b0;
    end else if (clk_en) begin
      vector_redirect_off <= run && opt_q[`FSP_OPT_REDIRECT_OFF];
    end
  end

  // Images loaded; software should wait for this before any access
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      images_ready <= 1'b0;
    end else if (clk_en) begin
      images_ready <= run;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register read port; data stands the cycle after the strobe only
  // A status read returns the bits and clears them in one strobe
  always_comb begin
    rdata_d = `FSP_RST_BYTE;
    if (reg_rd) begin
      if (reg_addr == `FSP_OFF_OPTION) begin
        rdata_d = opt_q;
      end else if (reg_addr == `FSP_OFF_CONFIG) begin
        rdata_d = cfg_q & `FSP_CFG_WR_MASK;
      end else if (reg_addr == `FSP_OFF_PROTECT) begin
        rdata_d = prot_q;
      end else if (reg_addr == `FSP_OFF_STATUS) begin
        rdata_d = stat_q;
      end else if (reg_addr == `FSP_OFF_MASK) begin
        rdata_d = mask_q;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= `FSP_RST_BYTE;
    end else if (clk_en) begin
      reg_rdata <= rdata_d;
    end
  end

endmodule

`default_nettype wire

// File: dv/fsp_core_model.sv
`default_nettype none

// Core and debug master on the memory gate
module fsp_core_model
  import fsp_pkg::*;
(
  input wire logic core_clk,
  output var fsp_acc_t mem_req
);
  timeunit 1ns;
  timeprecision 1ns;

  initial mem_req = '0;

  // One access per call; calls in a row give one per cycle
  task automatic acc(input logic dbg, input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    mem_req <= '{1'b1, dbg, wr, a, d};
  endtask

  // Released data flips so a stale byte never looks fresh
  task automatic idle();
    @(posedge core_clk);
    mem_req.valid <= 1'b0;
    mem_req.data <= ~mem_req.data;
  endtask
endmodule

`default_nettype wire

// File: dv/fsp_top_props.sv
`include "fsp_defs.svh"
`default_nettype none

// Port checks; clk_en low pauses everything
module fsp_top_props
  import fsp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] nv_option_source,
  input wire fsp_acc_t mem_req,
  input wire logic mem_grant,
  input wire logic mem_block,
  input wire fsp_cmd_t launch_out,
  input wire fsp_cmd_t cmd_in,
  input wire fsp_cmd_t cmd_go,
  input wire logic blank_ok,
  input wire logic secured,
  input wire logic images_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n || !clk_en);

  ////////////////////////////////////////////////////////////
  sequence s_dbg_req;
    mem_req.valid && mem_req.dbg && images_ready;
  endsequence
  sequence s_blank;
    blank_ok && images_ready ##2 1'b1;
  endsequence

  property p_dbg_block;
    s_dbg_req ##1 secured |-> mem_block && !mem_grant;
  endproperty
  a_dbg_block: assert property (p_dbg_block) else $error("debug access not blocked");
  property p_core_grant;
    images_ready && mem_req.valid && !mem_req.dbg |=> mem_grant;
  endproperty
  a_core_grant: assert property (p_core_grant) else $error("core access not granted");
  property p_one_answer;
    mem_grant || mem_block |-> $past(mem_req.valid) && !(mem_grant && mem_block);
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("gate answer without request");
  property p_cfg_low;
    reg_rd && reg_addr == `FSP_OFF_CONFIG |=> reg_rdata[4:0] == 5'h00;
  endproperty
  a_cfg_low: assert property (p_cfg_low) else $error("config low bits not zero");
  property p_opt_fixed;
    reg_rd && reg_addr == `FSP_OFF_OPTION |=> reg_rdata[7:2] == {nv_option_source[7:6], 4'h0};
  endproperty
  a_opt_fixed: assert property (p_opt_fixed) else $error("option image changed");
  property p_launch;
    launch_out.valid |-> $past(mem_req.valid && mem_req.wr && mem_req.addr inside {[16'hFFB0:16'hFFB7]})
      && launch_out.code == $past(mem_req.data);
  endproperty
  a_launch: assert property (p_launch) else $error("launch without window write");
  property p_go;
    cmd_go.valid |-> $past(cmd_in.valid) && cmd_go.code == $past(cmd_in.code) && cmd_go.addr == $past(cmd_in.addr);
  endproperty
  a_go: assert property (p_go) else $error("command passed without cause");
  property p_blank;
    s_blank |-> !secured;
  endproperty
  a_blank: assert property (p_blank) else $error("blank check did not unsecure");
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
endmodule

bind fsp_top fsp_top_props u_fsp_top_props(.core_clk, .rst_n, .clk_en, .reg_addr, .reg_rd, .reg_rdata,
  .nv_option_source, .mem_req, .mem_grant, .mem_block, .launch_out, .cmd_in, .cmd_go, .blank_ok, .secured,
  .images_ready);

`default_nettype wire

// File: dv/tb_top.sv
`include "fsp_defs.svh"
`default_nettype none

module tb_top
  import fsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk = 0, rst_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, reg_dbg = 0, blank_ok = 0;
  logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata, nv_option_source = 8'hC0;
  logic [7:0] nv_protect_source = 8'hFC; // Boundary 7E, last open byte FDFF
  logic [63:0] nv_unlock_key = 64'h8877665544332211; // Arbitrary key
  fsp_acc_t mem_req;
  fsp_cmd_t launch_out, cmd_go, cmd_in = '0;
  logic mem_grant, mem_block, secured, vector_redirect_off, images_ready, irq;
  int miscompares = 0, n_compared = 0, cyc = 0;
  typedef struct packed {logic dbg; logic [7:0] a, d, q;} fsp_row_t;
  // Write, then the value read back
  fsp_row_t rows[8] = '{'{0, `FSP_OFF_CONFIG, 8'hFF, 8'hE0}, '{0, `FSP_OFF_CONFIG, 8'h00, 8'h00},
    '{0, `FSP_OFF_OPTION, 8'h00, 8'hC0}, '{0, `FSP_OFF_PROTECT, 8'h00, 8'hFC},
    '{1, `FSP_OFF_PROTECT, 8'hFD, 8'hFD}, '{1, `FSP_OFF_PROTECT, 8'hFC, 8'hFC},
    '{0, 8'h07, 8'h55, 8'h00}, '{0, `FSP_OFF_MASK, 8'hFF, 8'h07}};

  fsp_top u_fsp_top(.core_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_dbg, .reg_rdata,
    .nv_option_source, .nv_protect_source, .nv_unlock_key, .mem_req, .mem_grant, .mem_block, .launch_out,
    .cmd_in, .cmd_go, .blank_ok, .secured, .vector_redirect_off, .images_ready, .irq);
  fsp_core_model u_fsp_core_model(.core_clk, .mem_req);

  initial forever #5 core_clk = ~core_clk;

  // Hang guard, far above the real run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic rst(input logic [7:0] opt);
    @(posedge core_clk);
    rst_n <= 0;
    nv_option_source <= opt;
    repeat (16) @(posedge core_clk);
    rst_n <= 1;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic dbg, input logic [7:0] a, d);
    @(posedge core_clk);
    reg_wr <= 1;
    reg_dbg <= dbg;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, exp);
    @(posedge core_clk);
    reg_rd <= 1;
    reg_dbg <= 0;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 0;
    #1 chk("reg_rdata", reg_rdata, exp);
  endtask

  task automatic cmd(input logic [7:0] c, input logic [15:0] a, input logic go);
    @(posedge core_clk);
    cmd_in <= '{1'b1, c, a};
    @(posedge core_clk);
    cmd_in.valid <= 0;
    #1 chk("cmd_go", cmd_go.valid, go);
  endtask

  // Whole key, bytes back to back in order; flip spoils byte 5
  task automatic key(input logic dbg, input logic [7:0] flip);
    for (int i = 0; i < 8; i++) begin
      u_fsp_core_model.acc(dbg, 1, 16'hFFB0 + 16'(i), nv_unlock_key[8*i+:8] ^ ((i == 5) ? flip : 8'h00));
    end
    u_fsp_core_model.idle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    rst(8'hC0);
    chk("ready", images_ready, 1);
    chk("secured", secured, 1);
    foreach (rows[i]) begin
      wr(rows[i].dbg, rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].q);
    end
    $display("register table done");
    cmd(8'h20, 16'hFDFF, 1);
    cmd(8'h25, 16'hFE00, 0);
    cmd(8'h40, 16'hFC00, 1);
    cmd(8'h40, 16'hFE00, 0);
    cmd(8'h41, 16'h0000, 0);
    cmd(8'h05, 16'hFE00, 1);
    chk("irq", irq, 1);
    rdc(`FSP_OFF_STATUS, 8'h01);
    wr(1, `FSP_OFF_PROTECT, 8'hFD);
    cmd(8'h41, 16'h0000, 1);
    cmd(8'h20, 16'hFFFF, 1);
    $display("protection done");
    u_fsp_core_model.acc(1, 0, 16'h0080, 8'h00);
    u_fsp_core_model.idle();
    #1 chk("mem_block", mem_block, 1);
    u_fsp_core_model.acc(0, 0, 16'h0080, 8'h00);
    u_fsp_core_model.idle();
    #1 chk("mem_grant", mem_grant, 1);
    rdc(`FSP_OFF_STATUS, 8'h04);
    u_fsp_core_model.acc(0, 1, 16'hFFB3, 8'hAB);
    u_fsp_core_model.idle();
    #1 chk("launch", {launch_out.valid, launch_out.code, launch_out.addr}, {1'b1, 8'hAB, 16'hFFB3});
    wr(0, `FSP_OFF_CONFIG, 8'h20);
    key(1, 8'h00);
    chk("secured", secured, 1);
    rdc(`FSP_OFF_STATUS, 8'h04);
    key(0, 8'h01);
    chk("secured", secured, 1);
    rdc(`FSP_OFF_STATUS, 8'h00);
    key(0, 8'h00);
    chk("secured", secured, 0);
    rdc(`FSP_OFF_STATUS, 8'h02);
    rdc(`FSP_OFF_OPTION, 8'hC2);
    rst(8'hC0);
    chk("secured", secured, 1);
    $display("backdoor done");
    rst(8'h40);
    wr(0, `FSP_OFF_CONFIG, 8'h20);
    key(0, 8'h00);
    chk("secured", secured, 1);
    // Strobe during a frozen clock enable is lost
    @(posedge core_clk);
    clk_en <= 0;
    wr(0, `FSP_OFF_CONFIG, 8'hE0);
    @(posedge core_clk);
    clk_en <= 1;
    rdc(`FSP_OFF_CONFIG, 8'h20);
    for (int i = 0; i < 4; i++) begin
      rst({1'b1, i[0], 4'h0, i[1:0]});
      chk("secured", secured, i != 2);
      chk("redirect", vector_redirect_off, i[0]);
    end
    @(posedge core_clk);
    blank_ok <= 1;
    @(posedge core_clk);
    blank_ok <= 0;
    repeat (2) @(posedge core_clk);
    #1 chk("secured", secured, 0);
    $display("security codes done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
